// [src/ecsb_bank.sv]
`timescale 1ns/10ps
module ecsb_bank #(
   parameter bit          HAS_MAC = 1'b1,
   parameter bit          HAS_PCS = 1'b1,
   parameter bit          HAS_PRE = 1'b0,
   parameter int          N_TX    = 4,
   parameter int          N_RX    = 4,
   parameter int          INC_W   = 16,
   // Arbitrary value, identifies nothing
   parameter logic [31:0] VERSION = 32'h0000_0100
) (
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             nrst,
   // AXI4-Lite write channels
   input  wire logic [31:0]                      s_axi_awaddr,
   input  wire logic                             s_axi_awvalid,
   output      logic                             s_axi_awready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output      logic                             s_axi_wready,
   output      logic [1:0]                       s_axi_bresp,
   output      logic                             s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [31:0]                      s_axi_araddr,
   input  wire logic                             s_axi_arvalid,
   output      logic                             s_axi_arready,
   output      logic [31:0]                      s_axi_rdata,
   output      logic [1:0]                       s_axi_rresp,
   output      logic                             s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   // Pins from outside the clock domain
   input  wire logic                             stats_snapshot_pulse,
   input  wire logic                             tx_reset,
   input  wire logic                             rx_reset,
   // Core events and counter increments
   input  wire logic [ecsb_pkg::NSTS-1:0][31:0]  sts_event,
   input  wire logic [N_TX-1:0][INC_W-1:0]       tx_stat_inc,
   input  wire logic [N_RX-1:0][INC_W-1:0]       rx_stat_inc,
   // Configuration words to the datapath
   output      logic [ecsb_pkg::NCFG+ecsb_pkg::NFC-1:0][31:0] cfg_words
);

   if (N_TX < 1 || N_TX > 32 || N_RX < 1 || N_RX > 32 ||
       INC_W < 1 || INC_W > 63)
   begin : g_bad_param
      $error("ecsb_bank: counter parameters out of range");
   end

   localparam int NCW = ecsb_pkg::NCFG + ecsb_pkg::NFC;

   typedef struct packed {
      logic                        snap_s1;
      logic                        snap_s2;
      logic                        txr_s1;
      logic                        txr_s2;
      logic                        rxr_s1;
      logic                        rxr_s2;
      logic                        awready;
      logic                        wready;
      logic                        bvalid;
      logic                        arready;
      logic                        rvalid;
      logic [31:0]                 rdata;
      logic [NCW-1:0][31:0]        cfg;
      logic [ecsb_pkg::NSTS-1:0][31:0] sts;
      logic [N_TX-1:0][63:0]       tx_acc;
      logic [N_TX-1:0][63:0]       tx_snap;
      logic [N_RX-1:0][63:0]       rx_acc;
      logic [N_RX-1:0][63:0]       rx_snap;
      logic [63:0]                 cyc_acc;
      logic [63:0]                 cyc_snap;
   } ecsb_state_t;

   ecsb_state_t                    r;
   ecsb_state_t                    next_r;
   logic [31:0]                    rd_val;
   logic                           wr_tick;
   logic                           snap;
   logic                           tx_rst;
   logic                           rx_rst;
   int                             ci;
   int                             wi;

   // Whether a feature class is present in this build
   function automatic logic feat_on(input ecsb_pkg::ecsb_feat_t f);
      logic on;
      on = 1'b0;
      unique case (f)
         ecsb_pkg::FEAT_ALL: on = 1'b1;
         ecsb_pkg::FEAT_MAC: on = HAS_MAC;
         ecsb_pkg::FEAT_PCS: on = HAS_PCS;
         ecsb_pkg::FEAT_PRE: on = HAS_PRE;
      endcase
      return on;
   endfunction : feat_on

   // Configuration slot for an address, or -1
   function automatic int cfg_find(input logic [31:0] a);
      int idx;
      idx = -1;
      if (a[31:12] == 20'h0_0000)
      begin
         for (int i = 0; i < ecsb_pkg::NCFG; i++)
         begin
            if (a[11:0] == ecsb_pkg::CFG_OFS[i] &&
                feat_on(ecsb_pkg::CFG_FEAT[i]))
               idx = i;
         end
         if (HAS_MAC && a[11:0] >= ecsb_pkg::FC_FIRST &&
             a[11:0] <= ecsb_pkg::FC_LAST && a[1:0] == 2'b00)
            idx = ecsb_pkg::NCFG +
                  int'((a[11:0] - ecsb_pkg::FC_FIRST) >> 2);
      end
      return idx;
   endfunction : cfg_find

   // Offset of one half of a statistics pair
   function automatic logic [11:0] stat_ofs(input logic [11:0] base,
                                            input int          i,
                                            input logic        hi);
      logic [11:0] o;
      o = base + 12'(i) * ecsb_pkg::STAT_STRIDE;
      if (hi)
         o = o + ecsb_pkg::STAT_HI_OFS;
      return o;
   endfunction : stat_ofs

   always_comb
   begin
      next_r  = r;
      rd_val  = '0;
      wr_tick = 1'b0;
      snap    = 1'b0;
      ci      = -1;
      wi      = -1;
      tx_rst  = r.txr_s2;
      rx_rst  = r.rxr_s2;

      // Pin synchronisers
      next_r.snap_s1 = stats_snapshot_pulse;
      next_r.snap_s2 = r.snap_s1;
      next_r.txr_s1  = tx_reset;
      next_r.txr_s2  = r.txr_s1;
      next_r.rxr_s1  = rx_reset;
      next_r.rxr_s2  = r.rxr_s1;

      // write address and data taken together
      next_r.awready = s_axi_awvalid && s_axi_wvalid && !r.bvalid &&
                       !r.awready;
      next_r.wready  = next_r.awready;
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      if (r.awready)
      begin
         next_r.bvalid = 1'b1;
         wi = cfg_find(s_axi_awaddr);
         if (wi >= 0)
         begin
            for (int b = 0; b < 4; b++)
            begin
               if (s_axi_wstrb[b])
                  next_r.cfg[wi][8*b +: 8] = s_axi_wdata[8*b +: 8];
            end
         end
         wr_tick = s_axi_awaddr == {20'h0_0000, ecsb_pkg::OFS_TICK} &&
                   s_axi_wstrb[0] && s_axi_wdata[ecsb_pkg::TICK_BIT];
      end

      next_r.arready = s_axi_arvalid && !r.arready && !r.rvalid;
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;

      // Core events; sticky flags
      for (int i = 0; i < ecsb_pkg::NSTS; i++)
      begin
         if (feat_on(ecsb_pkg::STS_FEAT[i]))
            next_r.sts[i] = r.sts[i] | sts_event[i];
      end

      if (r.arready)
      begin
         next_r.rvalid = 1'b1;
         if (s_axi_araddr[31:12] == 20'h0_0000)
         begin
            ci = cfg_find(s_axi_araddr);
            if (ci >= 0)
               rd_val = r.cfg[ci];
            if (s_axi_araddr[11:0] == ecsb_pkg::OFS_VER)
               rd_val = VERSION;
            for (int i = 0; i < ecsb_pkg::NSTS; i++)
            begin
               if (s_axi_araddr[11:0] == ecsb_pkg::STS_OFS[i] &&
                   feat_on(ecsb_pkg::STS_FEAT[i]))
               begin
                  rd_val = r.sts[i];
                  // clear on read, event this cycle kept
                  next_r.sts[i] = sts_event[i];
               end
            end
            if (s_axi_araddr[11:0] == ecsb_pkg::CYC_LO)
               rd_val = r.cyc_snap[31:0];
            if (s_axi_araddr[11:0] == ecsb_pkg::CYC_HI)
               rd_val = r.cyc_snap[63:32];
            if (HAS_MAC)
            begin
               for (int i = 0; i < N_TX; i++)
               begin
                  if (s_axi_araddr[11:0] ==
                      stat_ofs(ecsb_pkg::TX_STAT_BASE, i, 1'b0))
                     rd_val = r.tx_snap[i][31:0];
                  if (s_axi_araddr[11:0] ==
                      stat_ofs(ecsb_pkg::TX_STAT_BASE, i, 1'b1))
                     rd_val = r.tx_snap[i][63:32];
               end
               for (int i = 0; i < N_RX; i++)
               begin
                  if (s_axi_araddr[11:0] ==
                      stat_ofs(ecsb_pkg::RX_STAT_BASE, i, 1'b0))
                     rd_val = r.rx_snap[i][31:0];
                  if (s_axi_araddr[11:0] ==
                      stat_ofs(ecsb_pkg::RX_STAT_BASE, i, 1'b1))
                     rd_val = r.rx_snap[i][63:32];
               end
            end
         end
         next_r.rdata = rd_val;
      end

      // host trigger already on the core clock
      snap = r.cfg[ecsb_pkg::CFG_MODE_IDX][ecsb_pkg::MODE_TICK_SEL] ?
             wr_tick : r.snap_s2;

      // copy and restart every accumulator together
      for (int i = 0; i < N_TX; i++)
      begin
         if (snap)
         begin
            next_r.tx_snap[i] = r.tx_acc[i];
            next_r.tx_acc[i]  = 64'(tx_stat_inc[i]);
         end
         else
            next_r.tx_acc[i] = r.tx_acc[i] + 64'(tx_stat_inc[i]);
      end
      for (int i = 0; i < N_RX; i++)
      begin
         if (snap)
         begin
            next_r.rx_snap[i] = r.rx_acc[i];
            next_r.rx_acc[i]  = 64'(rx_stat_inc[i]);
         end
         else
            next_r.rx_acc[i] = r.rx_acc[i] + 64'(rx_stat_inc[i]);
      end
      if (snap)
      begin
         next_r.cyc_snap = r.cyc_acc;
         next_r.cyc_acc  = 64'h0000_0000_0000_0001;
      end
      else
         next_r.cyc_acc = r.cyc_acc + 64'h0000_0000_0000_0001;

      for (int i = 0; i < ecsb_pkg::NSTS; i++)
      begin
         if ((ecsb_pkg::STS_SIDE[i] == ecsb_pkg::SIDE_TX && tx_rst) ||
             (ecsb_pkg::STS_SIDE[i] == ecsb_pkg::SIDE_RX && rx_rst))
            next_r.sts[i] = '0;
      end
      if (tx_rst)
      begin
         next_r.tx_acc  = '0;
         next_r.tx_snap = '0;
      end
      if (rx_rst)
      begin
         next_r.rx_acc   = '0;
         next_r.rx_snap  = '0;
         next_r.cyc_acc  = '0;
         next_r.cyc_snap = '0;
      end

      if (!nrst)
      begin
         next_r.snap_s1 = 1'b0;
         next_r.snap_s2 = 1'b0;
         next_r.txr_s1  = 1'b0;
         next_r.txr_s2  = 1'b0;
         next_r.rxr_s1  = 1'b0;
         next_r.rxr_s2  = 1'b0;
         next_r.awready = 1'b0;
         next_r.wready  = 1'b0;
         next_r.bvalid  = 1'b0;
         next_r.arready = 1'b0;
         next_r.rvalid  = 1'b0;
         next_r.rdata   = '0;
         next_r.cfg     = '0;
         // host register is the default source
         next_r.cfg[ecsb_pkg::CFG_MODE_IDX] = ecsb_pkg::MODE_RST;
         next_r.sts     = '0;
         next_r.tx_acc  = '0;
         next_r.rx_acc  = '0;
         next_r.cyc_acc = '0;
         // snapshot words left as they are
      end
   end

   always_ff @(posedge mclk)
   begin
      r <= next_r;
   end

   assign s_axi_awready = r.awready;
   assign s_axi_wready  = r.wready;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = ecsb_pkg::RESP_OKAY;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = ecsb_pkg::RESP_OKAY;
   assign cfg_words     = r.cfg;

endmodule : ecsb_bank

// [src/ecsb_pkg.sv]
package ecsb_pkg;

   // Map sizes
   localparam int NCFG = 21;
   localparam int NFC  = 34;
   localparam int NSTS = 21;

   // Fixed offsets
   localparam logic [11:0] OFS_MODE     = 12'h008;
   localparam logic [11:0] OFS_TICK     = 12'h020;
   localparam logic [11:0] OFS_VER      = 12'h024;
   localparam logic [11:0] FC_FIRST     = 12'h040;
   localparam logic [11:0] FC_LAST      = 12'h0C4;
   localparam logic [11:0] CYC_LO       = 12'h500;
   localparam logic [11:0] CYC_HI       = 12'h504;
   localparam logic [11:0] TX_STAT_BASE = 12'h700;
   localparam logic [11:0] RX_STAT_BASE = 12'h808;
   localparam logic [11:0] STAT_STRIDE  = 12'h008;
   localparam logic [11:0] STAT_HI_OFS  = 12'h004;

   // Fields and reset values
   localparam int          CFG_MODE_IDX  = 2;
   localparam int          MODE_TICK_SEL = 30;
   localparam int          TICK_BIT      = 0;
   localparam logic [31:0] MODE_RST      = 32'h4000_0000;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;

   typedef enum logic [1:0] {
      FEAT_ALL = 2'b00,
      FEAT_MAC = 2'b01,
      FEAT_PCS = 2'b10,
      FEAT_PRE = 2'b11
   } ecsb_feat_t;

   typedef enum logic [1:0] {
      SIDE_TX  = 2'b00,
      SIDE_RX  = 2'b01,
      SIDE_GEN = 2'b10
   } ecsb_side_t;

   localparam logic [11:0] CFG_OFS [NCFG] = '{
      12'h000, 12'h004, 12'h008, 12'h00C, 12'h014, 12'h018, 12'h01C,
      12'h038, 12'h0D0, 12'h0D4, 12'h0E0, 12'h0E4, 12'h0F8, 12'h100,
      12'h104, 12'h108, 12'h10C, 12'h110, 12'h130, 12'h138, 12'h19C};
   localparam ecsb_feat_t CFG_FEAT [NCFG] = '{
      FEAT_ALL, FEAT_ALL, FEAT_ALL, FEAT_ALL, FEAT_ALL, FEAT_MAC, FEAT_ALL,
      FEAT_MAC, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS,
      FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_ALL, FEAT_PRE};

   localparam logic [11:0] STS_OFS [NSTS] = '{
      12'h400, 12'h404, 12'h408, 12'h40C, 12'h43C, 12'h448, 12'h44C,
      12'h450, 12'h454, 12'h458, 12'h45C, 12'h460, 12'h464, 12'h468,
      12'h46C, 12'h470, 12'h474, 12'h494, 12'h498, 12'h49C, 12'h9F0};
   localparam ecsb_feat_t STS_FEAT [NSTS] = '{
      FEAT_ALL, FEAT_ALL, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS,
      FEAT_MAC, FEAT_MAC, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS,
      FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_PCS, FEAT_ALL, FEAT_PRE, FEAT_PCS};
   localparam ecsb_side_t STS_SIDE [NSTS] = '{
      SIDE_TX,  SIDE_RX,  SIDE_GEN, SIDE_RX,  SIDE_RX,  SIDE_RX,  SIDE_TX,
      SIDE_TX,  SIDE_RX,  SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_GEN,
      SIDE_GEN, SIDE_GEN, SIDE_GEN, SIDE_RX,  SIDE_GEN, SIDE_GEN, SIDE_GEN};

endpackage : ecsb_pkg

// [tb/ecsb_bank_sva.sv]
`timescale 1ns/10ps
module ecsb_bank_sva (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Configuration words
   input wire logic [ecsb_pkg::NCFG+ecsb_pkg::NFC-1:0][31:0] cfg_words
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence s_wr_req;
      s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   endsequence
   sequence s_wr_ack;
      s_axi_awready && s_axi_wready ##1 s_axi_bvalid && !s_axi_awready;
   endsequence
   sequence s_rd_req;
      s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   endsequence
   sequence s_rd_ack;
      s_axi_arready ##1 s_axi_rvalid && !s_axi_arready;
   endsequence

   a_write_walk: assert property (s_wr_req |=> s_wr_ack)
      else $error("write handshake out of step");
   a_read_walk: assert property (s_rd_req |=> s_rd_ack)
      else $error("read handshake out of step");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid)
      else $error("write response repeated");
   a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=>
      !s_axi_rvalid)
      else $error("read response repeated");
   a_bresp_okay: assert property (s_axi_bvalid |->
      s_axi_bresp == ecsb_pkg::RESP_OKAY)
      else $error("write response not okay");
   a_rresp_okay: assert property (s_axi_rvalid |->
      s_axi_rresp == ecsb_pkg::RESP_OKAY)
      else $error("read response not okay");
   a_reset_clear: assert property (disable iff (1'b0) !nrst |=>
      !s_axi_bvalid && !s_axi_rvalid
      && cfg_words[ecsb_pkg::CFG_MODE_IDX] == ecsb_pkg::MODE_RST)
      else $error("bus reset left state behind");
endmodule : ecsb_bank_sva

bind ecsb_bank ecsb_bank_sva chk_u (.mclk, .nrst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .cfg_words);

// [tb/ecsb_host.sv]
`timescale 1ns/10ps
module ecsb_host (
   // Clock
   input  wire logic        mclk,
   // Write channels
   output      logic [31:0] s_axi_awaddr,
   output      logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output      logic [31:0] s_axi_wdata,
   output      logic [3:0]  s_axi_wstrb,
   output      logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   output      logic        s_axi_bready,
   // Read channels
   output      logic [31:0] s_axi_araddr,
   output      logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        s_axi_rvalid,
   output      logic        s_axi_rready
);
   int cyc = 0;
   int aw_cyc;

   always @(posedge mclk)
      cyc <= cyc + 1;

   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      s_axi_wstrb = 4'hF;
   end

   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0]  s = 4'hF);
      @(negedge mclk);
      s_axi_awaddr  = a;
      s_axi_wdata   = d;
      s_axi_wstrb   = s;
      s_axi_awvalid = 1'b1;
      s_axi_wvalid  = 1'b1;
      @(negedge mclk);
      for (int k = 0; k < 20 && s_axi_wready !== 1'b1; k++) @(negedge mclk);
      aw_cyc = cyc;
      @(negedge mclk);
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_awaddr  = ~a;
      s_axi_wdata   = ~d;
      for (int k = 0; k < 20 && s_axi_bvalid !== 1'b1; k++) @(negedge mclk);
      repeat ($urandom_range(2)) @(negedge mclk);
      s_axi_bready = 1'b1;
      @(negedge mclk);
      s_axi_bready = 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(negedge mclk);
      s_axi_araddr  = a;
      s_axi_arvalid = 1'b1;
      @(negedge mclk);
      for (int k = 0; k < 20 && s_axi_arready !== 1'b1; k++) @(negedge mclk);
      @(negedge mclk);
      s_axi_arvalid = 1'b0;
      s_axi_araddr  = ~a;
      for (int k = 0; k < 20 && s_axi_rvalid !== 1'b1; k++) @(negedge mclk);
      repeat ($urandom_range(2)) @(negedge mclk);
      s_axi_rready = 1'b1;
      d = s_axi_rdata;
      @(negedge mclk);
      s_axi_rready = 1'b0;
   endtask : rd
endmodule : ecsb_host

// [tb/tb_ethernet_csr_stats_bank.sv]
`timescale 1ns/10ps
`define CHK(g, e) cmp(g, e)
module tb_ethernet_csr_stats_bank;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, mclk, nrst, snap, tx_rst, rx_rst;
   logic [ecsb_pkg::NSTS-1:0][31:0] ev;
   logic [3:0][15:0] tx_inc, rx_inc;
   logic [ecsb_pkg::NCFG+ecsb_pkg::NFC-1:0][31:0] cfg;
   logic [31:0] sts_m [ecsb_pkg::NSTS];
   logic [63:0] tx_acc [4], rx_acc [4], tx_snp [4], rx_snp [4];
   logic [31:0] a, d, e, md, v;
   logic [31:0] rsv [6] = '{32'h10, 32'hC8, 32'h134, 32'h28, 32'h49C,
                            32'h1000_0008};
   logic        mode_sel;
   int          checks = 0, miscompares = 0, cycles = 0, t1;

   ecsb_bank dut_u (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stats_snapshot_pulse(snap),
      .tx_reset(tx_rst), .rx_reset(rx_rst), .sts_event(ev),
      .tx_stat_inc(tx_inc), .rx_stat_inc(rx_inc), .cfg_words(cfg));
   ecsb_host host_u (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

   task automatic cmp(input logic [31:0] got, input logic [31:0] want);
      checks++;
      if (got !== want)
      begin
         miscompares++;
         $display("Error at %0t ns: got %h expected %h", $time, got, want);
      end
   endtask : cmp

   task automatic tally_and_finish();
      if (miscompares == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic raise_all();
      @(negedge mclk);
      for (int k = 0; k < ecsb_pkg::NSTS; k++)
      begin
         ev[k] = $urandom();
         if (ecsb_pkg::STS_FEAT[k] != ecsb_pkg::FEAT_PRE)
            sts_m[k] |= ev[k];
      end
      @(negedge mclk);
      ev = '0;
   endtask : raise_all

   task automatic read_all();
      for (int k = 0; k < ecsb_pkg::NSTS; k++)
      begin
         host_u.rd({20'h0, ecsb_pkg::STS_OFS[k]}, v);
         `CHK(v, sts_m[k]); // sticky value
         sts_m[k] = '0;
      end
   endtask : read_all

   task automatic feed();
      for (int c = 0; c < 6; c++)
      begin
         @(negedge mclk);
         for (int k = 0; k < 4; k++)
         begin
            tx_inc[k] = 16'($urandom());
            rx_inc[k] = 16'($urandom());
            tx_acc[k] += tx_inc[k];
            rx_acc[k] += rx_inc[k];
         end
      end
      @(negedge mclk);
      {tx_inc, rx_inc} = '0;
   endtask : feed

   task automatic trig(input bit pulse, input logic [31:0] dt);
      if (pulse)
      begin
         @(negedge mclk);
         snap = 1'b1;
         @(negedge mclk);
         snap = 1'b0;
         repeat (3) @(negedge mclk);
      end
      else
         host_u.wr({20'h0, ecsb_pkg::OFS_TICK}, dt);
      if (pulse ? !mode_sel : (mode_sel && dt[0]))
      begin
         tx_snp = tx_acc;
         rx_snp = rx_acc;
         tx_acc = '{default: '0};
         rx_acc = '{default: '0};
      end
   endtask : trig

   task automatic check_snap();
      for (int k = 0; k < 8; k++)
      begin
         host_u.rd({20'h0, ecsb_pkg::TX_STAT_BASE} + 4 * k, v);
         `CHK(v, tx_snp[k / 2][32 * (k % 2) +: 32]); // transmit words
         host_u.rd({20'h0, ecsb_pkg::RX_STAT_BASE} + 4 * k, v);
         `CHK(v, rx_snp[k / 2][32 * (k % 2) +: 32]); // receive words
      end
   endtask : check_snap

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end

   initial
   begin
      void'($urandom(54991));
      {nrst, snap, tx_rst, rx_rst, mode_sel} = 5'h01;
      {ev, tx_inc, rx_inc} = '0;
      sts_m = '{default: '0};
      tx_acc = '{default: '0};
      rx_acc = '{default: '0};
      repeat (8) @(negedge mclk);
      nrst = 1'b1;
      host_u.rd({20'h0, ecsb_pkg::OFS_MODE}, v);
      `CHK(v, ecsb_pkg::MODE_RST); // default source
      for (int i = 0; i < ecsb_pkg::NCFG + ecsb_pkg::NFC; i++)
      begin
         a = (i < ecsb_pkg::NCFG) ? {20'h0, ecsb_pkg::CFG_OFS[i]}
             : {20'h0, ecsb_pkg::FC_FIRST} + 4 * (i - ecsb_pkg::NCFG);
         d = $urandom() | 32'h4000_0000;
         e = (i < ecsb_pkg::NCFG && ecsb_pkg::CFG_FEAT[i] ==
              ecsb_pkg::FEAT_PRE) ? 32'h0 : d;
         if (i == ecsb_pkg::CFG_MODE_IDX)
            md = d;
         host_u.wr(a, d);
         host_u.rd(a, v);
         `CHK(v, e); // readback
         `CHK(cfg[i], e); // word at port
      end
      foreach (rsv[j])
      begin
         host_u.wr(rsv[j], $urandom());
         host_u.rd(rsv[j], v);
         `CHK(v, 32'h0); // reads zero
      end
      host_u.rd({20'h0, ecsb_pkg::OFS_MODE}, v);
      `CHK(v, md); // writes ignored
      for (int s = 0; s < 3; s++)
      begin
         feed();
         raise_all();
         raise_all();
         host_u.wr({20'h0, ecsb_pkg::STS_OFS[0]}, 32'hFFFF_FFFF);
         {nrst, tx_rst, rx_rst} = (s == 0) ? 3'h5 : (s == 1) ? 3'h6 : 3'h0;
         repeat (4) @(negedge mclk);
         {nrst, tx_rst, rx_rst} = 3'h4;
         repeat (3) @(negedge mclk);
         for (int k = 0; k < ecsb_pkg::NSTS; k++)
            if (s == 2 || ecsb_pkg::STS_SIDE[k] ==
                (s == 0 ? ecsb_pkg::SIDE_RX : ecsb_pkg::SIDE_TX))
               sts_m[k] = '0;
         if (s != 1)
            rx_acc = '{default: '0};
         if (s != 0)
            tx_acc = '{default: '0};
         read_all();
         read_all();
         host_u.rd(s == 0 ? 32'h808 : 32'h700, v);
         if (s < 2)
            `CHK(v, 32'h0); // side snapshot
      end
      host_u.rd({20'h0, ecsb_pkg::OFS_MODE}, v);
      `CHK(v, ecsb_pkg::MODE_RST); // bus reset
      host_u.wr({20'h0, ecsb_pkg::OFS_VER}, 32'h0);
      host_u.rd({20'h0, ecsb_pkg::OFS_VER}, v);
      `CHK(v, 32'h0000_0100); // version word read-only
      host_u.wr(32'hC, 32'hFFFF_FFFF, 4'h5);
      host_u.rd(32'hC, v);
      `CHK(v, 32'h00FF_00FF); // byte strobes
      `CHK(cfg[3], 32'h00FF_00FF); // strobed word at port
      trig(1'b0, 32'h1);
      check_snap();
      t1 = host_u.aw_cyc;
      feed();
      trig(1'b0, 32'h1);
      check_snap();
      host_u.rd({20'h0, ecsb_pkg::CYC_LO}, v);
      `CHK(v, host_u.aw_cyc - t1); // cycle count
      host_u.rd({20'h0, ecsb_pkg::CYC_HI}, v);
      `CHK(v, 32'h0); // upper word
      feed();
      trig(1'b0, 32'hFFFF_FFFE);
      host_u.wr({20'h0, ecsb_pkg::OFS_TICK}, 32'h1, 4'hE);
      trig(1'b1, 32'h0);
      trig(1'b0, 32'h1);
      check_snap();
      trig(1'b0, 32'h1);
      check_snap();
      host_u.wr({20'h0, ecsb_pkg::OFS_MODE}, 32'h0);
      mode_sel = 1'b0;
      feed();
      trig(1'b0, 32'h1);
      trig(1'b1, 32'h0);
      check_snap();
      trig(1'b1, 32'h0);
      check_snap();
      tally_and_finish();
   end
endmodule : tb_ethernet_csr_stats_bank
